// [shared/acc_logic_params.svh]
// Constants for the accumulator logic and/or unit
`ifndef ACC_LOGIC_PARAMS_SVH
`define ACC_LOGIC_PARAMS_SVH

// ----------------------------------------------------------------
// Data widths
// ----------------------------------------------------------------
`define ACC_W 32
`define ACC_MSB 31
`define WORD_W 16
`define CNT_W 6

// ----------------------------------------------------------------
// Stack geometry
// ----------------------------------------------------------------
`define STACK_DEPTH 8
`define STACK_LVL_W 4

// ----------------------------------------------------------------
// Formatted bit count limits and reset values
// ----------------------------------------------------------------
`define FMT_CNT_MIN 6'h01
`define FMT_CNT_MAX 6'h20
`define ACC_RST 32'h0000_0000
`define STACK_RST 32'h0000_0000
`define LVL_ONE 4'h1

`endif

// [shared/acc_logic_pkg.sv]
// Types shared by the accumulator logic and/or unit
package acc_logic_pkg;

    // ------------------------------------------------------------
    // Operation codes, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_AND_STACK    = 4'b0001,
        OP_OR_WORD      = 4'b0010,
        OP_OR_DOUBLE    = 4'b0100,
        OP_OR_FORMATTED = 4'b1000
    } acc_op_e;

    // ------------------------------------------------------------
    // Command from the sequencer and operand fetch logic
    // ------------------------------------------------------------
    typedef struct packed {
        acc_op_e op;
        logic [15:0] word_lo;
        logic [15:0] word_hi;
        logic use_const;
        logic [31:0] const_val;
        logic [31:0] disc_bits;
        logic [5:0] bit_count;
    } acc_cmd_s;

    // ------------------------------------------------------------
    // Status flags with their update strobes
    // ------------------------------------------------------------
    typedef struct packed {
        logic zero_result_flag;
        logic negative_result_flag;
        logic zero_updated;
        logic negative_updated;
    } acc_flags_s;

endpackage

// [verilog/accumulator_logic_and_or_unit.sv]
// Accumulator logic datapath: and-with-stack and the or family
`include "acc_logic_params.svh"

module accumulator_logic_and_or_unit
    import acc_logic_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire acc_cmd_s cmd_i,
    input wire logic acc_load_i,
    input wire logic [31:0] acc_load_data_i,
    input wire logic stack_push_i,
    input wire logic [31:0] stack_push_data_i,
    output logic [31:0] acc_o,
    output logic [31:0] stack_top_o,
    output logic [3:0] stack_level_o,
    output acc_flags_s flags_o,
    output logic done_o,
    output logic cmd_error_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] acc_reg;
    logic [31:0] stack_reg [`STACK_DEPTH];
    logic [3:0] level_reg;
    logic zero_reg;
    logic negative_reg;
    logic zero_upd_reg;
    logic negative_upd_reg;
    logic done_reg;
    logic error_reg;

    // ------------------------------------------------------------
    // Decode and result
    // ------------------------------------------------------------
    logic [31:0] result_next;
    logic acc_wr;
    logic upd_zero;
    logic upd_negative;
    logic stack_pop;
    logic cmd_bad;
    logic cnt_ok;
    logic [31:0] fmt_mask;
    logic [31:0] double_operand;
    logic push_take;
    logic load_take;

    // One mask bit per accumulator bit, set below the count
    genvar b;
    generate
        for (b = 0; b < `ACC_W; b = b + 1)
        begin : g_mask
            assign fmt_mask[b] = (6'(b) < cmd_i.bit_count);
        end
    endgenerate

    // Count outside 1..32 cannot be a legal run
    assign cnt_ok = (cmd_i.bit_count >= `FMT_CNT_MIN) &&
                    (cmd_i.bit_count <= `FMT_CNT_MAX);

    // Immediate or memory pair, high word in the upper half
    assign double_operand = cmd_i.use_const ? cmd_i.const_val
                          : {cmd_i.word_hi, cmd_i.word_lo};

    // Command decode; an illegal op or count only raises the error, leaving accumulator, stack and flag values alone
    always_comb
    begin
        result_next = acc_reg;
        acc_wr = 1'b0;
        upd_zero = 1'b0;
        upd_negative = 1'b0;
        stack_pop = 1'b0;
        cmd_bad = 1'b0;
        if (cmd_valid_i)
        begin
            unique case (cmd_i.op)
                OP_AND_STACK:
                begin
                    result_next = acc_reg & stack_reg[0];
                    acc_wr = 1'b1;
                    stack_pop = 1'b1;
                    upd_zero = 1'b1;
                    upd_negative = 1'b1;
                end
                OP_OR_WORD:
                begin
                    result_next = {acc_reg[31:16],
                                   acc_reg[15:0] | cmd_i.word_lo};
                    acc_wr = 1'b1;
                    upd_zero = 1'b1;
                end
                OP_OR_DOUBLE:
                begin
                    result_next = acc_reg | double_operand;
                    acc_wr = 1'b1;
                    upd_zero = 1'b1;
                    upd_negative = 1'b1;
                end
                OP_OR_FORMATTED:
                begin
                    if (cnt_ok)
                    begin
                        result_next = acc_reg | (cmd_i.disc_bits & fmt_mask);
                        acc_wr = 1'b1;
                        upd_zero = 1'b1;
                        upd_negative = 1'b1;
                    end
                    else
                    begin
                        cmd_bad = 1'b1;
                    end
                end
                default:
                begin
                    cmd_bad = 1'b1;
                end
            endcase
        end
    end

    // Maintenance ports yield to a command in the same cycle
    assign load_take = acc_load_i && !cmd_valid_i;
    assign push_take = stack_push_i && !cmd_valid_i;

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------

    // Written by an operation or by a direct load
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            acc_reg <= `ACC_RST;
        end
        else if (acc_wr)
        begin
            acc_reg <= result_next;
        end
        else if (load_take)
        begin
            acc_reg <= acc_load_data_i;
        end
    end

    // ------------------------------------------------------------
    // Accumulator stack
    // ------------------------------------------------------------

    // Pop moves every entry up; bottom refills with zero
    genvar s;
    generate
        for (s = 0; s < `STACK_DEPTH; s = s + 1)
        begin : g_stack
            always_ff @(posedge sys_clk_i)
            begin
                if (sys_rst_i)
                begin
                    stack_reg[s] <= `STACK_RST;
                end
                else if (stack_pop)
                begin
                    if (s == `STACK_DEPTH - 1)
                    begin
                        stack_reg[s] <= `STACK_RST;
                    end
                    else
                    begin
                        stack_reg[s] <= stack_reg[(s + 1) % `STACK_DEPTH];
                    end
                end
                else if (push_take)
                begin
                    if (s == 0)
                    begin
                        stack_reg[s] <= stack_push_data_i;
                    end
                    else
                    begin
                        stack_reg[s] <= stack_reg[(s + `STACK_DEPTH - 1) % `STACK_DEPTH]; // Wrap keeps dead index legal
                    end
                end
            end
        end
    endgenerate

    // Occupancy; a push on a full stack drops the bottom entry
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            level_reg <= '0;
        end
        else if (stack_pop)
        begin
            if (level_reg != '0)
            begin
                level_reg <= level_reg - `LVL_ONE;
            end
        end
        else if (push_take)
        begin
            if (level_reg != 4'(`STACK_DEPTH))
            begin
                level_reg <= level_reg + `LVL_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------

    // Each flag is only touched by an op that writes it
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            zero_reg <= 1'b0;
        end
        else if (upd_zero)
        begin
            zero_reg <= (result_next == `ACC_RST);
        end
    end

    // Word or leaves this one standing on purpose
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            negative_reg <= 1'b0;
        end
        else if (upd_negative)
        begin
            negative_reg <= result_next[`ACC_MSB];
        end
    end

    // Update strobes tell consumers a flag value was replaced
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            zero_upd_reg <= 1'b0;
            negative_upd_reg <= 1'b0;
        end
        else
        begin
            zero_upd_reg <= upd_zero;
            negative_upd_reg <= upd_negative;
        end
    end

    // ------------------------------------------------------------
    // Completion
    // ------------------------------------------------------------

    // Single-cycle ops: done or error pulses one edge after take
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            done_reg <= 1'b0;
            error_reg <= 1'b0;
        end
        else
        begin
            done_reg <= acc_wr;
            error_reg <= cmd_bad;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------
    assign acc_o = acc_reg;
    assign stack_top_o = stack_reg[0];
    assign stack_level_o = level_reg;
    assign flags_o = '{zero_result_flag: zero_reg,
                       negative_result_flag: negative_reg,
                       zero_updated: zero_upd_reg,
                       negative_updated: negative_upd_reg};
    assign done_o = done_reg;
    assign cmd_error_o = error_reg;

endmodule

// [testbench/acc_logic_chk.sv]
// Concurrent checks on the accumulator logic unit ports
module acc_logic_chk
    import acc_logic_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire acc_cmd_s cmd_i,
    input wire logic acc_load_i,
    input wire logic [31:0] acc_load_data_i,
    input wire logic stack_push_i,
    input wire logic [31:0] stack_push_data_i,
    input wire logic [31:0] acc_o,
    input wire logic [31:0] stack_top_o,
    input wire logic [3:0] stack_level_o,
    input wire acc_flags_s flags_o,
    input wire logic done_o,
    input wire logic cmd_error_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Each result tied to the operands seen one edge earlier
    and_stack_a: assert property (cmd_valid_i && cmd_i.op == OP_AND_STACK |=>
        done_o && acc_o == ($past(acc_o) & $past(stack_top_o))) else $error("and with stack result wrong");
    pop_level_a: assert property (cmd_valid_i && cmd_i.op == OP_AND_STACK && stack_level_o != 4'h0 |=>
        stack_level_o == $past(stack_level_o) - 4'h1) else $error("stack level not lowered");
    and_flags_a: assert property (cmd_valid_i && cmd_i.op == OP_AND_STACK |=>
        flags_o.zero_updated && flags_o.negative_updated) else $error("and with stack flags not updated");
    or_word_a: assert property (cmd_valid_i && cmd_i.op == OP_OR_WORD |=>
        acc_o == {$past(acc_o[31:16]), $past(acc_o[15:0]) | $past(cmd_i.word_lo)}) else $error("word or wrong");
    word_neg_a: assert property (cmd_valid_i && cmd_i.op == OP_OR_WORD |=>
        !flags_o.negative_updated && $stable(flags_o.negative_result_flag)) else $error("word or moved negative");
    or_double_a: assert property (cmd_valid_i && cmd_i.op == OP_OR_DOUBLE |=> acc_o == ($past(acc_o) |
        ($past(cmd_i.use_const) ? $past(cmd_i.const_val) : {$past(cmd_i.word_hi), $past(cmd_i.word_lo)})))
        else $error("or double result wrong");
    bad_count_a: assert property (cmd_valid_i && cmd_i.op == OP_OR_FORMATTED && cmd_i.bit_count == 6'h00 |=>
        cmd_error_o && !done_o && $stable(acc_o)) else $error("zero bit count accepted");
    zero_flag_a: assert property (flags_o.zero_updated |->
        flags_o.zero_result_flag == (acc_o == 32'h0000_0000)) else $error("zero flag wrong");
    neg_flag_a: assert property (flags_o.negative_updated |->
        flags_o.negative_result_flag == acc_o[31]) else $error("negative flag wrong");
    flag_hold_a: assert property (!flags_o.zero_updated && !$past(sys_rst_i) |->
        $stable(flags_o.zero_result_flag)) else $error("zero flag moved without writer");
endmodule

bind accumulator_logic_and_or_unit acc_logic_chk acc_logic_chk_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .acc_load_i(acc_load_i), .acc_load_data_i(acc_load_data_i),
    .stack_push_i(stack_push_i), .stack_push_data_i(stack_push_data_i), .acc_o(acc_o), .stack_top_o(stack_top_o),
    .stack_level_o(stack_level_o), .flags_o(flags_o), .done_o(done_o), .cmd_error_o(cmd_error_o));

// [testbench/seq_model.sv]
// Sequencer and operand fetch model driving the unit
module seq_model
    import acc_logic_pkg::*;
(
    input wire logic sys_clk_i,
    output logic cmd_valid_o,
    output acc_cmd_s cmd_o,
    output logic acc_load_o,
    output logic [31:0] acc_load_data_o,
    output logic stack_push_o,
    output logic [31:0] stack_push_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle at time zero
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
        acc_load_o = 1'b0;
        acc_load_data_o = 32'h0000_0000;
        stack_push_o = 1'b0;
        stack_push_data_o = 32'h0000_0000;
    end

    // One command for one cycle; released lines show the inverse, not stale data
    task send(input acc_cmd_s c);
        @(posedge sys_clk_i);
        #1;
        cmd_o = c;
        cmd_valid_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_o = ~c;
    endtask

    // Load accumulator and optionally push in the same cycle
    task seed(input logic [31:0] a, input logic [31:0] s, input logic p);
        @(posedge sys_clk_i);
        #1;
        acc_load_o = 1'b1;
        acc_load_data_o = a;
        stack_push_o = p;
        stack_push_data_o = s;
        @(posedge sys_clk_i);
        #1;
        acc_load_o = 1'b0;
        stack_push_o = 1'b0;
        acc_load_data_o = ~a;
        stack_push_data_o = ~s;
    endtask
endmodule

// [testbench/accumulator_logic_and_or_unit_test.sv]
// Self-checking bench for the accumulator logic unit
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module accumulator_logic_and_or_unit_test
    import acc_logic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cmd_valid, acc_load, stack_push, done, cmd_error;
    acc_cmd_s cmd;
    acc_flags_s flags;
    logic [31:0] acc_load_data, stack_push_data, acc, stack_top;
    logic [3:0] stack_level;
    int n_tests = 0;
    int n_mismatch = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    seq_model seq_model_i (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .acc_load_o(acc_load),
        .acc_load_data_o(acc_load_data), .stack_push_o(stack_push), .stack_push_data_o(stack_push_data));
    accumulator_logic_and_or_unit accumulator_logic_and_or_unit_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .cmd_valid_i(cmd_valid), .cmd_i(cmd), .acc_load_i(acc_load), .acc_load_data_i(acc_load_data),
        .stack_push_i(stack_push), .stack_push_data_i(stack_push_data), .acc_o(acc), .stack_top_o(stack_top),
        .stack_level_o(stack_level), .flags_o(flags), .done_o(done), .cmd_error_o(cmd_error));

    // Send one op; the wrong operand source carries the inverse so a mix-up shows
    task automatic op(input acc_op_e o, input logic [31:0] v, input logic uc, input logic [5:0] bc,
        input logic [31:0] ea, input logic ez, input logic en, input logic ee);
        seq_model_i.send('{o, uc ? ~v[15:0] : v[15:0], uc ? ~v[31:16] : v[31:16], uc, uc ? v : ~v, v, bc});
        `CHK(acc, ea)
        `CHK(done, !ee)
        `CHK(cmd_error, ee)
        `CHK(flags.zero_result_flag, ez)
        `CHK(flags.negative_result_flag, en)
        `CHK(flags.zero_updated, !ee)
    endtask

    task t_and_stack;
        op(OP_AND_STACK, 32'h0000_0000, 1'b0, 6'h01, 32'h0000_0000, 1'b1, 1'b0, 1'b0);
        `CHK(stack_level, 4'h0)
        seq_model_i.seed(32'hFFFF_0000, 32'h8000_1234, 1'b1);
        `CHK(stack_top, 32'h8000_1234)
        op(OP_AND_STACK, 32'h0000_0000, 1'b0, 6'h01, 32'h8000_0000, 1'b0, 1'b1, 1'b0);
        `CHK(stack_level, 4'h0)
        `CHK(stack_top, 32'h0000_0000)
        $display("test and_stack done");
    endtask

    task t_or_word;
        op(OP_OR_WORD, 32'hFFFF_00A5, 1'b0, 6'h01, 32'h8000_00A5, 1'b0, 1'b1, 1'b0);
        seq_model_i.seed(32'h0000_0000, 32'h0000_0000, 1'b0);
        op(OP_OR_WORD, 32'h0000_0000, 1'b0, 6'h01, 32'h0000_0000, 1'b1, 1'b1, 1'b0);
        $display("test or_word done");
    endtask

    task t_or_double;
        seq_model_i.seed(32'h0000_0001, 32'h0000_0000, 1'b0);
        op(OP_OR_DOUBLE, 32'h8000_0010, 1'b0, 6'h01, 32'h8000_0011, 1'b0, 1'b1, 1'b0);
        seq_model_i.seed(32'h0000_0001, 32'h0000_0000, 1'b0);
        op(OP_OR_DOUBLE, 32'h0000_0100, 1'b1, 6'h01, 32'h0000_0101, 1'b0, 1'b0, 1'b0);
        seq_model_i.seed(32'h0000_0000, 32'h0000_0000, 1'b0);
        op(OP_OR_DOUBLE, 32'h0000_0000, 1'b1, 6'h01, 32'h0000_0000, 1'b1, 1'b0, 1'b0);
        $display("test or_double done");
    endtask

    task t_or_formatted;
        seq_model_i.seed(32'h0000_0006, 32'h0000_0000, 1'b0);
        op(OP_OR_FORMATTED, 32'hFFFF_FFF8, 1'b0, 6'h04, 32'h0000_000E, 1'b0, 1'b0, 1'b0);
        op(OP_OR_FORMATTED, 32'h8000_0000, 1'b0, 6'h20, 32'h8000_000E, 1'b0, 1'b1, 1'b0);
        op(OP_OR_FORMATTED, 32'hFFFF_FFFF, 1'b0, 6'h01, 32'h8000_000F, 1'b0, 1'b1, 1'b0);
        op(OP_OR_FORMATTED, 32'h7FFF_FFF0, 1'b0, 6'h00, 32'h8000_000F, 1'b0, 1'b1, 1'b1);
        op(OP_OR_FORMATTED, 32'h7FFF_FFF0, 1'b0, 6'h21, 32'h8000_000F, 1'b0, 1'b1, 1'b1);
        op(acc_op_e'(4'h0), 32'h7FFF_FFF0, 1'b1, 6'h01, 32'h8000_000F, 1'b0, 1'b1, 1'b1);
        $display("test or_formatted done");
    endtask

    // Full stack saturates; a command shuts out load and push; mid-run reset clears
    task t_stack;
        repeat (9) seq_model_i.seed(32'h0000_0000, 32'h0000_0011, 1'b1);
        `CHK(stack_level, 4'h8)
        fork
            seq_model_i.seed(32'hFFFF_FFFF, 32'h0000_0022, 1'b1);
            op(OP_OR_FORMATTED, 32'h0000_0000, 1'b0, 6'h00, 32'h0000_0000, 1'b0, 1'b1, 1'b1);
        join
        `CHK(stack_level, 4'h8)
        `CHK(stack_top, 32'h0000_0011)
        @(posedge sys_clk_i);
        #1;
        sys_rst_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        sys_rst_i = 1'b0;
        `CHK(stack_level, 4'h0)
        `CHK(stack_top, 32'h0000_0000)
        `CHK(flags.negative_result_flag, 1'b0)
        $display("test stack done");
    endtask

    task results;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence after an 8-cycle reset
    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        #1;
        sys_rst_i = 1'b0;
        t_and_stack();
        t_or_word();
        t_or_double();
        t_or_formatted();
        t_stack();
        results();
    end

    // Watchdog at 1000 cycles; the run needs under 70 cycles
    initial
    begin
        #4000;
        n_mismatch++;
        results();
    end
endmodule
